/* File: smc_pkg.sv */
/*
 * smc_pkg: constants and types for the sleep-mode clock controller.
 * Assumes a single 100 MHz system clock and an AHB-Lite register bus.
 */
package smc_pkg;

	// register byte addresses
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_REDUCTION = 8'h04;
	localparam logic [7:0] ADDR_STATUS = 8'h08;

	// control register fields
	localparam int GATE_EN_BIT = 5;
	localparam int MODE_LO = 3;
	localparam logic [1:0] MODE_IDLE = 2'h0;
	localparam logic [1:0] MODE_NOISE = 2'h1;
	localparam logic [1:0] MODE_PDOWN = 2'h2;
	localparam logic [1:0] MODE_STBY = 2'h3;
	localparam logic [7:0] CTRL_RESET = 8'h00;

	// peripheral_power_reduction fields
	localparam int PR_CONV = 0;
	localparam int PR_SER = 1;
	localparam int PR_T8 = 2;
	localparam int PR_T16 = 3;
	localparam logic [3:0] REDUCTION_RESET = 4'h0;

	// gate vector positions
	localparam int G_CPU = 0;
	localparam int G_FLASH = 1;
	localparam int G_IO = 2;
	localparam int G_ADC = 3;
	localparam int G_OSC = 4;
	localparam int G_T16 = 5;
	localparam int G_T8 = 6;
	localparam int G_SER = 7;
	localparam int G_CONV = 8;
	localparam int NGATES = 9;
	localparam logic [8:0] GATE_RESET = 9'h1ff;

	// timing in system clock cycles
	localparam logic [3:0] HALT_CYCLES = 4'h4;
	localparam int STANDBY_WAKE_CYCLES = 6;
	localparam logic [15:0] STARTUP_DEFAULT = 16'h0010;

	typedef enum logic [1:0] {
		ST_ACTIVE,
		ST_SLEEP,
		ST_STARTUP,
		ST_HALT
	} smc_state_t;

	typedef enum logic [1:0] {
		SM_IDLE,
		SM_NOISE,
		SM_PDOWN,
		SM_STBY
	} smc_mode_t;

endpackage : smc_pkg

/* File: smc_gate_bank.sv */
/*
 * smc_gate_bank: one flip-flop per clock gate enable.
 * Assumes next enables are settled before each rising edge of hclk.
 */
`timescale 1ns/1ns
module smc_gate_bank
	import smc_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic [NGATES-1:0] next_gate,
	output logic [NGATES-1:0] gate
);

	// outside the asynchronous reset, each enable changes only at a clock edge, so the gated clocks
	// downstream never see a partial pulse
	genvar i;
	generate
		for (i = 0; i < NGATES; i++) begin : g_gate
			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					gate[i] <= GATE_RESET[i];
				end else begin
					gate[i] <= next_gate[i];
				end
			end
		end
	endgenerate

endmodule : smc_gate_bank

/* File: smc_sleep_ctrl.sv */
/*
 * smc_sleep_ctrl: sleep mode entry, wake-up sequencing, domain clock
 * gating and per-peripheral power reduction, with an AHB-Lite slave.
 * Assumes the core pulses sleep_exec on its sleep instruction and that
 * wake and reset request inputs are synchronous to hclk.
 */
// The address map and the AHB-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ns
// What this block does
// - sleep only with gate enable set; mode 00 stops processor and flash clocks.
// - after wake, processor held four cycles beyond start-up, then resumes.
// - mode 01 stops I/O, processor and flash clocks; converter, oscillator run.
// - noise mode wakes on conversion done, resets, store ready, level, pin change.
// - enabled converter starts a conversion on entering noise-reduction mode.
// - mode 10 is power-down: oscillator and all generated clocks stop.
// - power-down wakes only on resets, first interrupt level, pin change, or watchdog interrupt.
// - mode 11 with crystal selected is standby: power-down with oscillator on.
// - standby resumes execution within six cycles of the wake event.
// - set reduction bit stops peripheral clock and blocks its register access.
// - clearing the bit restarts the clock; peripheral state is kept.
// - bit 3 stops the 16-bit timer clock, bit 2 the 8-bit timer clock.
// - bit 1 stops the serial unit clock; software reinitialises it afterwards.
// - bit 0 shuts down the converter, which software disables beforehand.
// - reduction register bits 7 to 4 always read zero.
// - per-module stopping matters in active and idle, and bit 0 in noise reduction too; deeper modes stop anyway.
// - power-down and standby disable the comparator unless it uses the reference.
// - in sleep with I/O and converter clocks stopped, digital input buffers are disabled.
// - converter stays enabled in sleep; re-enable forces an extended conversion.
// - an enabled watchdog keeps running in every sleep mode.
module smc_sleep_ctrl
	import smc_pkg::*;
#(
	parameter logic [15:0] STARTUP_CYCLES = STARTUP_DEFAULT
)
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic sleep_exec,
	input wire logic crystal_selected,
	input wire logic conv_done,
	input wire logic ext_reset_req,
	input wire logic wdt_reset_req,
	input wire logic bod_reset_req,
	input wire logic store_ready,
	input wire logic first_external_interrupt_level,
	input wire logic first_external_interrupt_edge,
	input wire logic pin_change,
	input wire logic wdt_irq,
	input wire logic other_irq,
	input wire logic converter_enable,
	input wire logic comparator_uses_ref,
	input wire logic watchdog_enable,
	output logic cpu_clk_en,
	output logic flash_clk_en,
	output logic io_clk_en,
	output logic adc_clk_en,
	output logic osc_en,
	output logic timer16_clk_en,
	output logic timer8_clk_en,
	output logic serial_clk_en,
	output logic converter_clk_en,
	output logic [3:0] periph_reg_block,
	output logic adc_auto_start,
	output logic comparator_disable,
	output logic digital_input_disable,
	output logic converter_run,
	output logic converter_extended_conversion,
	output logic watchdog_run
);

	// registers and state
	logic sleep_gate_enable;
	logic [1:0] sleep_mode_select;
	logic [3:0] peripheral_power_reduction;
	smc_state_t state;
	smc_mode_t mode;
	logic [15:0] cnt;
	logic [7:0] addr_q;
	logic wr_q;
	logic conv_en_q;
	logic [NGATES-1:0] gate;

	default clocking cb_sys @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	// mode code to sleep type; 11 without a crystal falls back to power-down
	function automatic smc_mode_t decode_mode(input logic [1:0] code,
		input logic xtal);
		unique case (code)
			MODE_IDLE: decode_mode = SM_IDLE;
			MODE_NOISE: decode_mode = SM_NOISE;
			MODE_PDOWN: decode_mode = SM_PDOWN;
			MODE_STBY: decode_mode = xtal ? SM_STBY : SM_PDOWN;
		endcase
	endfunction : decode_mode

	// domain enables {osc, adc, io, flash, cpu} for a state and mode
	function automatic logic [4:0] domain_gates(input smc_state_t st,
		input smc_mode_t md);
		unique case (st)
			ST_ACTIVE: domain_gates = 5'h1f;
			ST_STARTUP: domain_gates = 5'h10;
			ST_HALT: domain_gates = 5'h1e;
			ST_SLEEP: begin
				unique case (md)
					SM_IDLE: domain_gates = 5'h1c;
					SM_NOISE: domain_gates = 5'h18;
					SM_PDOWN: domain_gates = 5'h00;
					SM_STBY: domain_gates = 5'h10;
				endcase
			end
		endcase
	endfunction : domain_gates

	// bus decode
	wire addr_phase = hsel && hready && htrans[1];
	wire wr_ctrl = wr_q && (addr_q == ADDR_CTRL);
	wire wr_reduction = wr_q && (addr_q == ADDR_REDUCTION);
	wire [7:0] rd_addr = haddr[7:0];
	wire [31:0] next_rdata =
		(rd_addr == ADDR_CTRL) ? {26'h0, sleep_gate_enable,
			sleep_mode_select, 3'h0} :
		(rd_addr == ADDR_REDUCTION) ? {28'h0, peripheral_power_reduction} :
		(rd_addr == ADDR_STATUS) ? {28'h0, 2'(mode), 2'(state)} :
		32'h0;

	// sleep entry and wake decision
	wire enter_sleep = (state == ST_ACTIVE) && sleep_exec &&
		sleep_gate_enable;
	wire [1:0] code_now = (wr_ctrl) ? hwdata[MODE_LO+1:MODE_LO] :
		sleep_mode_select;
	wire smc_mode_t next_mode_sel = decode_mode(sleep_mode_select,
		crystal_selected);
	wire any_reset = ext_reset_req || wdt_reset_req || bod_reset_req;
	wire deep_wake = any_reset || first_external_interrupt_level ||
		pin_change || wdt_irq;
	wire noise_wake = deep_wake || conv_done || store_ready;
	wire idle_wake = noise_wake || first_external_interrupt_edge ||
		other_irq;
	wire wake =
		(mode == SM_IDLE) ? idle_wake :
		(mode == SM_NOISE) ? noise_wake :
		deep_wake;
	wire needs_startup = (mode == SM_PDOWN);
	wire halt_done = (cnt[3:0] == HALT_CYCLES - 4'h1);
	wire startup_done = (cnt == STARTUP_CYCLES - 16'h1);

	// state machine
	smc_state_t next_state;
	always_comb begin
		next_state = state;
		unique case (state)
			ST_ACTIVE: begin
				if (enter_sleep) begin
					next_state = ST_SLEEP;
				end
			end
			ST_SLEEP: begin
				if (wake) begin
					// oscillator restarts only after power-down
					next_state = needs_startup ? ST_STARTUP : ST_HALT;
				end
			end
			ST_STARTUP: begin
				if (startup_done) begin
					next_state = ST_HALT;
				end
			end
			ST_HALT: begin
				if (halt_done) begin
					next_state = ST_ACTIVE;
				end
			end
		endcase
	end

	wire [15:0] next_cnt = (next_state != state) ? 16'h0 : cnt + 16'h1;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state <= ST_ACTIVE;
			mode <= SM_IDLE;
			cnt <= 16'h0;
		end else begin
			state <= next_state;
			cnt <= next_cnt;
			if (enter_sleep) begin
				mode <= next_mode_sel;
			end
		end
	end

	// register bus
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			addr_q <= 8'h0;
			wr_q <= 1'b0;
			hrdata <= 32'h0;
		end else begin
			wr_q <= addr_phase && hwrite;
			if (addr_phase) begin
				addr_q <= haddr[7:0];
			end
			if (addr_phase && !hwrite) begin
				hrdata <= next_rdata;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sleep_gate_enable <= CTRL_RESET[GATE_EN_BIT];
			sleep_mode_select <= CTRL_RESET[MODE_LO+1:MODE_LO];
			peripheral_power_reduction <= REDUCTION_RESET;
		end else begin
			if (wr_ctrl) begin
				sleep_gate_enable <= hwdata[GATE_EN_BIT];
				sleep_mode_select <= code_now;
			end
			if (wr_reduction) begin
				// upper bits are not stored, so they always read zero
				peripheral_power_reduction <= hwdata[3:0];
			end
		end
	end

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	// gate enables
	wire [4:0] dom = domain_gates(next_state, enter_sleep ? next_mode_sel :
		mode);
	wire [3:0] pr = peripheral_power_reduction;
	// in power-down and standby the io/adc terms are already low, so reduction
	// bits only matter in active and idle, and bit 0 also in noise reduction
	wire [NGATES-1:0] next_gate = {
		dom[G_ADC] & ~pr[PR_CONV],
		dom[G_IO] & ~pr[PR_SER],
		dom[G_IO] & ~pr[PR_T8],
		dom[G_IO] & ~pr[PR_T16],
		dom
	};

	smc_gate_bank smc_gate_bank_inst (
		.hclk(hclk),
		.hresetn(hresetn),
		.next_gate(next_gate),
		.gate(gate)
	);

	assign cpu_clk_en = gate[G_CPU];
	assign flash_clk_en = gate[G_FLASH];
	assign io_clk_en = gate[G_IO];
	assign adc_clk_en = gate[G_ADC];
	assign osc_en = gate[G_OSC];
	assign timer16_clk_en = gate[G_T16];
	assign timer8_clk_en = gate[G_T8];
	assign serial_clk_en = gate[G_SER];
	assign converter_clk_en = gate[G_CONV];
	assign periph_reg_block = peripheral_power_reduction;

	// analog side controls
	wire deep = (state == ST_SLEEP) && (mode == SM_PDOWN || mode == SM_STBY);
	wire auto_start = enter_sleep && converter_enable &&
		!peripheral_power_reduction[PR_CONV] &&
		(next_mode_sel == SM_NOISE || next_mode_sel == SM_IDLE);
	wire next_inbuf_off = (state == ST_SLEEP) && !dom[G_IO] && !dom[G_ADC];

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			adc_auto_start <= 1'b0;
			comparator_disable <= 1'b0;
			digital_input_disable <= 1'b0;
			converter_run <= 1'b0;
			watchdog_run <= 1'b0;
			conv_en_q <= 1'b0;
			converter_extended_conversion <= 1'b0;
		end else begin
			adc_auto_start <= auto_start;
			comparator_disable <= deep && !comparator_uses_ref;
			digital_input_disable <= next_inbuf_off;
			converter_run <= converter_enable;
			watchdog_run <= watchdog_enable;
			conv_en_q <= converter_enable;
			// a fresh enable wins over a completion in the same cycle
			if (converter_enable && !conv_en_q) begin
				converter_extended_conversion <= 1'b1;
			end else if (conv_done) begin
				converter_extended_conversion <= 1'b0;
			end
		end
	end

	// checks
	a_sleep_needs_gate: assert property (
		(state == ST_ACTIVE && sleep_exec && !sleep_gate_enable)
		|=> state == ST_ACTIVE) else $error("sleep entered without enable");

	a_idle_gate_cpu: assert property (
		(enter_sleep && next_mode_sel == SM_IDLE) |-> ##2
		(!cpu_clk_en && !flash_clk_en && io_clk_en && adc_clk_en))
		else $error("idle gating wrong");

	sequence s_halt_four;
		(state == ST_HALT) [*4] ##1 (state == ST_ACTIVE);
	endsequence
	a_halt_four_cyc: assert property (
		$rose(state == ST_HALT) |-> s_halt_four)
		else $error("halt not four cycles");

	a_noise_gates: assert property (
		(enter_sleep && next_mode_sel == SM_NOISE) |-> ##2
		(!io_clk_en && !cpu_clk_en && adc_clk_en && osc_en))
		else $error("noise mode gating wrong");

	a_noise_wake_only: assert property (
		(state == ST_SLEEP && mode == SM_NOISE && !noise_wake)
		|=> state == ST_SLEEP) else $error("noise mode woke wrongly");

	a_auto_conv: assert property (
		(enter_sleep && next_mode_sel == SM_NOISE && converter_enable &&
		!peripheral_power_reduction[PR_CONV]) |=> adc_auto_start)
		else $error("no auto conversion");

	a_pdown_osc_off: assert property (
		(enter_sleep && next_mode_sel == SM_PDOWN) |-> ##2
		(!osc_en && !adc_clk_en && !io_clk_en))
		else $error("power-down clocks running");

	a_pdown_wake_only: assert property (
		(state == ST_SLEEP && mode == SM_PDOWN && !deep_wake)
		|=> state == ST_SLEEP) else $error("power-down woke wrongly");

	a_standby_six: assert property (
		(state == ST_SLEEP && mode == SM_STBY && wake) |-> ##[1:6] cpu_clk_en)
		else $error("standby wake too slow");

	a_red_stops_t16: assert property (
		(peripheral_power_reduction[PR_T16] &&
		$stable(peripheral_power_reduction)) |=> !timer16_clk_en)
		else $error("timer16 clock not stopped");

	a_cmp_auto_off: assert property (
		(deep && !comparator_uses_ref) |=> comparator_disable)
		else $error("comparator left on");

endmodule : smc_sleep_ctrl

/* File: smc_wake_model.sv */
/* smc_wake_model: wake-up event sources beside the sleep controller.
 * Assumes fire is a one-cycle request from the bench, synchronous to hclk. */
`timescale 1ns/1ns
module smc_wake_model (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic fire,
	input wire logic [2:0] kind,
	input wire logic cpu_clk_en,
	output logic [6:0] evt
);
	// pulses last one cycle; the level source holds until the core runs
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			evt <= 7'h00;
		end else if (fire) begin
			evt <= 7'h01 << kind;
		end else begin
			evt <= evt & (cpu_clk_en ? 7'h00 : 7'h04);
		end
	end
endmodule : smc_wake_model

/* File: tb_smc_sleep_ctrl.sv */
/* tb_smc_sleep_ctrl: self-checking bench for the sleep controller.
 * Assumes smc_pkg and the wake model are compiled first. */
`timescale 1ns/1ns
module tb_smc_sleep_ctrl;
	import smc_pkg::*;
	// short start-up keeps power-down wakes quick
	localparam logic [15:0] ST = 16'h0002;
	logic hclk, hresetn, hsel, hwrite, sleep_exec, crystal_selected;
	logic [31:0] haddr, hwdata, hrdata, rd, v, pv;
	logic [1:0] htrans, m, em;
	logic [2:0] hsize, kind, k;
	logic hreadyout, hresp, fire, auto_seen, ce, cr, we;
	logic [2:0] rreq;
	logic converter_enable, comparator_uses_ref, watchdog_enable;
	logic cpu_clk_en, flash_clk_en, io_clk_en, adc_clk_en, osc_en;
	logic timer16_clk_en, timer8_clk_en, serial_clk_en, converter_clk_en;
	logic [3:0] periph_reg_block;
	logic adc_auto_start, comparator_disable, digital_input_disable;
	logic converter_run, converter_extended_conversion, watchdog_run;
	logic [6:0] evt;
	int fails, num_checks, i, n, lo;
	wire logic [4:0] dom = {osc_en, adc_clk_en, io_clk_en, flash_clk_en,
		cpu_clk_en};
	wire logic [3:0] per = {timer16_clk_en, timer8_clk_en, serial_clk_en,
		converter_clk_en};

	smc_sleep_ctrl #(.STARTUP_CYCLES(ST)) smc_sleep_ctrl_inst (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
		.hrdata(hrdata), .sleep_exec(sleep_exec),
		.crystal_selected(crystal_selected), .conv_done(evt[0]),
		.ext_reset_req(rreq[0]), .wdt_reset_req(rreq[1]),
		.bod_reset_req(rreq[2]), .store_ready(evt[1]),
		.first_external_interrupt_level(evt[2]),
		.first_external_interrupt_edge(evt[3]),
		.pin_change(evt[4]), .wdt_irq(evt[5]), .other_irq(evt[6]),
		.converter_enable(converter_enable),
		.comparator_uses_ref(comparator_uses_ref),
		.watchdog_enable(watchdog_enable), .cpu_clk_en(cpu_clk_en),
		.flash_clk_en(flash_clk_en), .io_clk_en(io_clk_en),
		.adc_clk_en(adc_clk_en), .osc_en(osc_en),
		.timer16_clk_en(timer16_clk_en), .timer8_clk_en(timer8_clk_en),
		.serial_clk_en(serial_clk_en), .converter_clk_en(converter_clk_en),
		.periph_reg_block(periph_reg_block), .adc_auto_start(adc_auto_start),
		.comparator_disable(comparator_disable),
		.digital_input_disable(digital_input_disable),
		.converter_run(converter_run),
		.converter_extended_conversion(converter_extended_conversion),
		.watchdog_run(watchdog_run)
	);
	smc_wake_model smc_wake_model_inst (.hclk(hclk), .hresetn(hresetn),
		.fire(fire), .kind(kind), .cpu_clk_en(cpu_clk_en), .evt(evt));

	initial begin
		hclk = 1'b0;
		forever #5 hclk = ~hclk;
	end
	// the start pulse is one cycle wide, so latch it
	always @(posedge hclk) begin
		if (adc_auto_start === 1'b1) auto_seen <= 1'b1;
	end

	function automatic logic [31:0] ctrl_val(input logic [1:0] md);
		return (32'h1 << GATE_EN_BIT) | ({30'h0, md} << MODE_LO);
	endfunction : ctrl_val
	function automatic logic [31:0] dom_exp(input logic [1:0] md);
		case (md)
			MODE_IDLE: return 32'h1c;
			MODE_NOISE: return 32'h18;
			MODE_STBY: return 32'h10;
			default: return 32'h0;
		endcase
	endfunction : dom_exp
	function automatic logic [31:0] per_exp(input logic [1:0] md,
		input logic [31:0] p);
		if (md == MODE_IDLE) return {28'h0, ~p[3:0]};
		if (md == MODE_NOISE) return {31'h0, ~p[0]};
		return 32'h0;
	endfunction : per_exp

	task complete_run;
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : complete_run
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			fails++;
			$display("CHECK FAILED %s exp %h got %h", nm, e, g);
		end
	endtask : chk
	task chk_rng(input string nm, input int lo_b, input int g);
		num_checks++;
		if (g < lo_b || g > lo_b + 2) begin
			fails++;
			$display("CHECK FAILED %s exp %0d..%0d got %0d", nm, lo_b,
				lo_b + 2, g);
		end
	endtask : chk_rng
	task cyc(input int c);
		repeat (c) @(posedge hclk);
		#1;
	endtask : cyc
	task wait_rdy;
		int t;
		t = 0;
		do begin
			@(posedge hclk);
			t++;
		end while (hreadyout !== 1'b1 && t < 20);
		if (t >= 20) begin
			fails++;
			complete_run;
		end
	endtask : wait_rdy
	task bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, a};
		wait_rdy;
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= wd;
		wait_rdy;
		rd = hrdata;
	endtask : bus
	task sleep_go;
		@(posedge hclk);
		sleep_exec <= 1'b1;
		@(posedge hclk);
		sleep_exec <= 1'b0;
		cyc(3);
	endtask : sleep_go
	task fire_evt(input logic [2:0] kk);
		@(posedge hclk);
		fire <= 1'b1;
		kind <= kk;
		@(posedge hclk);
		fire <= 1'b0;
		#1;
	endtask : fire_evt

	initial begin
		fails = 0;
		num_checks = 0;
		{hresetn, hsel, hwrite, sleep_exec, fire, auto_seen} = 6'h0;
		{haddr, hwdata, htrans, kind} = '0;
		rreq = 3'h0;
		hsize = 3'h2;
		crystal_selected = 1'b1;
		{converter_enable, comparator_uses_ref, watchdog_enable} = 3'h0;
		void'($urandom(8999));
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		cyc(1);
		chk("dom_rst", 32'h1f, {27'h0, dom});
		bus(1'b0, ADDR_REDUCTION, 32'h0);
		chk("red_rst", 32'h0, rd);
		chk("hresp", 32'h0, {31'h0, hresp});
		for (i = 0; i < 6; i++) begin
			v = (i == 0) ? 32'hffffffff : (i == 1) ? 32'h0 : $urandom;
			bus(1'b1, ADDR_REDUCTION, v);
			bus(1'b0, ADDR_REDUCTION, 32'h0);
			chk("red_rd", {28'h0, v[3:0]}, rd);
			cyc(2);
			chk("per_en", per_exp(MODE_IDLE, v),
				{28'h0, per});
			chk("reg_blk", {28'h0, v[3:0]}, {28'h0, periph_reg_block});
		end
		bus(1'b1, 8'h0c, 32'hffffffff);
		bus(1'b0, 8'h0c, 32'h0);
		chk("unmapped", 32'h0, rd);
		$display("test registers done");
		bus(1'b1, ADDR_CTRL, ctrl_val(MODE_PDOWN) & 32'h18);
		sleep_go;
		chk("no_gate", 32'h1f, {27'h0, dom});
		for (i = 0; i < 5; i++) begin
			m = (i == 4) ? MODE_STBY : i[1:0];
			em = (i == 4) ? MODE_PDOWN : m;
			{ce, cr, we} = 3'($urandom);
			// software must stop the converter before shutting it down
			pv = ce ? ($urandom & 32'hfffffffe) : $urandom;
			crystal_selected <= (i != 4);
			{converter_enable, comparator_uses_ref, watchdog_enable} <=
				{ce, cr, we};
			bus(1'b1, ADDR_REDUCTION, pv);
			bus(1'b1, ADDR_CTRL, ctrl_val(m));
			auto_seen = 1'b0;
			sleep_go;
			chk("dom_slp", dom_exp(em), {27'h0, dom});
			chk("per_slp", per_exp(em, pv), {28'h0, per});
			chk("cmp_dis", {31'h0, em[1] & ~cr},
				{31'h0, comparator_disable});
			chk("din_dis", {31'h0, em[1]}, {31'h0, digital_input_disable});
			chk("conv_run", {31'h0, ce}, {31'h0, converter_run});
			chk("wdt_run", {31'h0, we}, {31'h0, watchdog_run});
			chk("auto_st", {31'h0, ce & ~em[1]}, {31'h0, auto_seen});
			bus(1'b0, ADDR_STATUS, 32'h0);
			chk("status", {28'h0, em, 2'h1}, rd);
			if (em != MODE_IDLE) begin
				fire_evt((em == MODE_NOISE) ? 3'd6 : (em == MODE_PDOWN) ? 3'd0 : 3'd1);
				cyc(12);
				chk("no_wake", 32'h0, {31'h0, cpu_clk_en});
			end
			k = (em == MODE_IDLE) ? 3'($urandom % 7) : (em == MODE_NOISE) ?
				3'd0 : (em == MODE_PDOWN) ? 3'd2 : 3'd4;
			if (i == 4) begin
				// a held reset request, timed like a model event
				@(posedge hclk);
				@(posedge hclk);
				rreq <= 3'h1 << ($urandom % 3);
				#1;
			end else begin
				fire_evt(k);
			end
			n = 0;
			do begin
				cyc(1);
				n++;
			end while (cpu_clk_en !== 1'b1 && n < 100);
			if (n >= 100) begin
				fails++;
				complete_run;
			end
			lo = (em == MODE_PDOWN) ? int'(ST) + 5 : 5;
			chk_rng("wake_cyc", lo, n);
			cyc(2);
			chk("dom_wake", 32'h1f, {27'h0, dom});
			rreq <= 3'h0;
			$display("test mode %0d done", i);
		end
		converter_enable <= 1'b0;
		cyc(3);
		converter_enable <= 1'b1;
		cyc(3);
		chk("ext_set", 32'h1, {31'h0, converter_extended_conversion});
		fire_evt(3'd0);
		cyc(2);
		chk("ext_clr", 32'h0, {31'h0, converter_extended_conversion});
		$display("test converter done");
		complete_run;
	end
endmodule : tb_smc_sleep_ctrl
